// File: common/mss_pkg.sv
package mss_pkg;
    // Register byte offsets
    localparam logic [11:0] MSS_REG_CTRL     = 12'h000;
    localparam logic [11:0] MSS_REG_TIMES    = 12'h004;
    localparam logic [11:0] MSS_REG_DCBRK    = 12'h008;
    localparam logic [11:0] MSS_REG_FREQ     = 12'h00C;
    localparam logic [11:0] MSS_REG_RATED    = 12'h010;
    localparam logic [11:0] MSS_REG_STATUS   = 12'h014;
    localparam logic [11:0] MSS_REG_VOUT     = 12'h018;
    // Codes
    localparam logic [2:0]  MSS_STOP_DEC     = 3'h0;
    localparam logic [2:0]  MSS_STOP_DCBRAKE = 3'h1;
    localparam logic [2:0]  MSS_STOP_FREERUN = 3'h2;
    localparam logic [2:0]  MSS_STOP_POWER   = 3'h4;
    localparam logic [5:0]  MSS_FN_PREEXCITE = 6'h22;
    localparam logic [8:0]  MSS_VRATED_MIN   = 9'h064;
    localparam logic [8:0]  MSS_VRATED_MAX   = 9'h1E0;
    // Reset values (times in 10 ms ticks, freq in 0.01 Hz, level in %)
    localparam logic [12:0] MSS_RST_BLOCK    = 13'h000A;
    localparam logic [12:0] MSS_RST_DCTIME   = 13'h0064;
    localparam logic [12:0] MSS_RST_STARTBRK = 13'h0000;
    localparam logic [15:0] MSS_RST_DCFREQ   = 16'h01F4;
    localparam logic [7:0]  MSS_RST_LEVEL    = 8'h32;
    localparam logic [12:0] MSS_TIME_MAX     = 13'h1770;
    localparam logic [15:0] MSS_FREQ_MAX     = 16'h1770;
    // Tick timing
    localparam int          MSS_TICK_NS      = 10_000_000;
    localparam int          MSS_CLK_NS       = 4;
    localparam int          MSS_TICK_CYC     = MSS_TICK_NS / MSS_CLK_NS;

    typedef enum logic [2:0] {
        MSS_ST_STOP  = 3'b000,
        MSS_ST_DCST  = 3'b001,
        MSS_ST_RUN   = 3'b010,
        MSS_ST_DEC   = 3'b011,
        MSS_ST_BLOCK = 3'b100,
        MSS_ST_DCBRK = 3'b101
    } mss_state_t;

    typedef struct packed {
        logic        gate_on;
        logic        dc_inject;
        logic [7:0]  dc_level;
        logic        ramp_up;
        logic        ramp_down;
        logic        hold_ramp;
        logic        stall_en;
    } mss_drive_t;
endpackage : mss_pkg

// File: dv/mss_motor_model.sv
`timescale 1ns/1ns
`default_nettype none
module mss_motor_model
    import mss_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire mss_drive_t  drive,
    input  wire logic [15:0] ref_freq,
    input  wire logic [15:0] step,
    output logic      [15:0] out_freq,
    output logic      [9:0]  bus_volt
);
    // Shaft speed: follows the ramp, coasts when not driven
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_freq <= 16'h0000;
        end else if (!drive.gate_on || drive.dc_inject) begin
            out_freq <= (out_freq > 16'h0014) ? out_freq - 16'h0014 : 16'h0000;
        end else if (drive.ramp_up && !drive.hold_ramp) begin
            out_freq <= (out_freq + step >= ref_freq) ? ref_freq : out_freq + step;
        end else if (drive.ramp_down && !drive.hold_ramp) begin
            out_freq <= (out_freq > step) ? out_freq - step : 16'h0000;
        end
    end

    // Regeneration lifts the bus while the ramp falls; holding lets it sag
    assign bus_volt = (drive.gate_on && drive.ramp_down && !drive.hold_ramp) ? 10'h02F8 : 10'h0258;
endmodule : mss_motor_model
`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import mss_pkg::*;
    logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic      [11:0] paddr;
    logic      [31:0] pwdata, prdata;
    logic             run_cmd, mfi_active, dwell_skip;
    logic      [5:0]  mfi_function;
    logic      [15:0] out_freq, ref_freq, base_freq, dwell_freq, step;
    logic      [8:0]  input_volt, out_volt;
    logic      [9:0]  bus_volt;
    mss_drive_t       drive;
    int               err_total, num_checks, dc_n, blk_n, inj_n, hold_n, both_n, stall_n;
    logic      [15:0] f_off;
    logic      [7:0]  lvl;

    mss_sequencer #(.TICK_CYC(4)) mss_sequencer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .run_cmd(run_cmd), .mfi_function(mfi_function),
        .mfi_active(mfi_active), .out_freq(out_freq), .ref_freq(ref_freq), .base_freq(base_freq),
        .dwell_freq(dwell_freq), .input_volt(input_volt), .bus_volt(bus_volt), .drive(drive),
        .out_volt(out_volt), .dwell_skip(dwell_skip));
    mss_motor_model mss_motor_model_inst (.pclk(pclk), .presetn(presetn), .drive(drive),
        .ref_freq(ref_freq), .step(step), .out_freq(out_freq), .bus_volt(bus_volt));

    // Free-running 250 MHz clock
    always #2 pclk = ~pclk;

    task automatic end_of_test();
        if (err_total == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Counts measured by the bench; slack covers the fixed pipeline edges
    task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
        num_checks++;
        // Unknown values must fail, not slip through the range test
        if ((got >= lo && got <= hi) !== 1'b1) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : chk_rng

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            err_total++;
            end_of_test();
        end
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(r & m, x);
    endtask : rd_chk

    function automatic logic [31:0] ctrl(input logic [2:0] m, input logic sdc, input logic sens);
        return {16'h0000, 8'h08, 1'b0, m, 2'b00, sens, sdc};
    endfunction : ctrl

    // Raise run and watch any DC phase until the ramp reaches reference
    task automatic start_run();
        int n;
        dc_n = 0;
        lvl  = 8'h00;
        run_cmd <= 1'b1;
        for (n = 0; n < 400; n++) begin
            @(posedge pclk);
            if (drive.dc_inject === 1'b1) begin
                dc_n++;
                lvl = drive.dc_level;
            end
            if (out_freq === ref_freq) break;
        end
        if (n == 400) begin
            err_total++;
            end_of_test();
        end
    endtask : start_run

    // Drop run and profile the stop over a fixed window
    task automatic stop_run();
        logic seen;
        seen = 1'b0;
        f_off = 16'hFFFF;
        {blk_n, inj_n, hold_n, both_n, stall_n} = '0;
        run_cmd <= 1'b0;
        repeat (300) begin
            @(posedge pclk);
            if (drive.gate_on !== 1'b1 && !seen) begin
                seen  = 1'b1;
                f_off = out_freq;
            end
            if (seen && inj_n == 0 && drive.gate_on === 1'b0 && drive.dc_inject === 1'b0) blk_n++;
            if (drive.dc_inject === 1'b1) begin
                inj_n++;
                lvl = drive.dc_level;
            end
            if (drive.hold_ramp === 1'b1) hold_n++;
            if (drive.stall_en === 1'b1) stall_n++;
            if (drive.hold_ramp === 1'b1 && drive.stall_en === 1'b1) both_n++;
        end
    endtask : stop_run

    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        rd_chk(MSS_REG_TIMES, 32'hFFFF_FFFF, 32'h0064_000A);
        rd_chk(MSS_REG_FREQ, 32'h0000_FFFF, 32'h0000_01F4);
        apb(1'b0, 12'h020, 32'h0000_0000, r, e);
        chk({31'h0, e}, 32'h0000_0001);
        wr(MSS_REG_STATUS, 32'h0000_0007);
        rd_chk(MSS_REG_STATUS, 32'h0000_0007, 32'h0000_0000);
        wr(MSS_REG_CTRL, ctrl(3'h3, 1'b0, 1'b0));
        rd_chk(MSS_REG_CTRL, 32'h0000_0070, 32'h0000_0000);
    endtask : t_regs

    task automatic t_volt();
        wr(MSS_REG_RATED, 32'h0046_0000);
        repeat (4) @(posedge pclk);
        chk({23'h0, out_volt}, 32'h0000_00C8);
        wr(MSS_REG_RATED, 32'h0046_00DC);
        repeat (4) @(posedge pclk);
        chk({23'h0, out_volt}, 32'h0000_00DC);
        wr(MSS_REG_RATED, 32'h0046_0032);
        rd_chk(MSS_REG_VOUT, 32'h0000_01FF, 32'h0000_00DC);
    endtask : t_volt

    task automatic t_misc();
        mfi_function <= MSS_FN_PREEXCITE;
        mfi_active   <= 1'b1;
        repeat (4) @(posedge pclk);
        chk({31'h0, drive.dc_inject}, 32'h0000_0001);
        chk({24'h0, drive.dc_level}, 32'h0000_0046);
        mfi_active <= 1'b0;
        wr(MSS_REG_CTRL, ctrl(MSS_STOP_DCBRAKE, 1'b0, 1'b0));
        dwell_freq <= 16'h012C;
        repeat (4) @(posedge pclk);
        chk({31'h0, drive.dc_inject}, 32'h0000_0000);
        chk({31'h0, dwell_skip}, 32'h0000_0001);
        dwell_freq <= 16'h02BC;
        repeat (4) @(posedge pclk);
        chk({31'h0, dwell_skip}, 32'h0000_0000);
    endtask : t_misc

    task automatic t_start();
        start_run();
        chk_rng(dc_n, 0, 0);
        input_volt <= 9'h17C;
        wr(MSS_REG_RATED, 32'h0046_0190);
        repeat (4) @(posedge pclk);
        chk({23'h0, out_volt}, 32'h0000_017C);
        wr(MSS_REG_RATED, 32'h0046_00DC);
        stop_run();
        chk({16'h0, f_off}, 32'h0000_0000);
        chk_rng(stall_n, 1, 300);
        wr(MSS_REG_CTRL, ctrl(MSS_STOP_DEC, 1'b1, 1'b0));
        step <= 16'h0014;
        start_run();
        chk_rng(dc_n, 6, 10);
        chk({24'h0, lvl}, 32'h0000_0046);
        stop_run();
        step <= 16'h0032;
        wr(MSS_REG_CTRL, ctrl(MSS_STOP_DEC, 1'b1, 1'b1));
        start_run();
        chk_rng(dc_n, 0, 0);
        stop_run();
    endtask : t_start

    task automatic t_stops();
        wr(MSS_REG_CTRL, ctrl(MSS_STOP_DCBRAKE, 1'b0, 1'b0));
        start_run();
        stop_run();
        chk_rng(f_off, 0, 500);
        chk_rng(blk_n, 5, 11);
        chk_rng(inj_n, 9, 15);
        chk({24'h0, lvl}, 32'h0000_0046);
        wr(MSS_REG_CTRL, ctrl(MSS_STOP_FREERUN, 1'b0, 1'b0));
        start_run();
        stop_run();
        chk_rng(f_off, 2850, 3000);
        wr(MSS_REG_CTRL, ctrl(MSS_STOP_POWER, 1'b0, 1'b0));
        start_run();
        stop_run();
        chk_rng(hold_n, 1, 300);
        chk_rng(both_n, 0, 0);
    endtask : t_stops

    // Main sequence: reset for 20 cycles, then the scenarios
    initial begin
        {err_total, num_checks} = '0;
        {pclk, presetn, psel, penable, pwrite, run_cmd, mfi_active} = '0;
        {paddr, pwdata, mfi_function} = '0;
        ref_freq   = 16'h0BB8;
        base_freq  = 16'h07D0;
        dwell_freq = 16'h02BC;
        step       = 16'h0032;
        input_volt = 9'h0C8;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        wr(MSS_REG_TIMES, 32'h0003_0002);
        wr(MSS_REG_DCBRK, 32'h505A_0002);
        t_volt();
        t_misc();
        wr(MSS_REG_CTRL, ctrl(MSS_STOP_DEC, 1'b0, 1'b0));
        t_start();
        t_stops();
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire

// File: rtl/mss_sequencer.sv
// Notes on behaviour
// RULE_01 - Rated voltage zero: output scaling from input voltage sampled while stopped.
// RULE_02 - Nonzero rated voltage 100..480 V is the output voltage at base frequency.
// RULE_03 - Above base frequency, clamp output voltage to a lower input voltage.
// RULE_04 - Start mode 0: run from stop ramps straight to reference, no DC.
// RULE_05 - Start mode 1: inject DC for start braking time, then accelerate.
// RULE_06 - Sensorless induction control suppresses DC before start.
// RULE_07 - Start and pre-excite DC amount capped at inverter rated current.
// RULE_08 - Stopped with function 34 input asserted: supply DC excitation.
// RULE_09 - Stop mode 0: ramp down to 0 Hz, then stop.
// RULE_10 - DC braking stop: decelerate, switch to DC at threshold frequency.
// RULE_11 - Block output for block interval before stop DC injection.
// RULE_12 - Stop DC injection lasts injection duration, then ends.
// RULE_13 - Stop braking level limited to inverter over motor rated current times 100.
// RULE_14 - Dwell frequency below DC threshold: skip dwell, brake instead.
// RULE_15 - Stop mode 2: output off at once, load coasts.
// RULE_16 - Stop mode 4: bus over threshold while decelerating flattens the slope.
// RULE_17 - Stall prevention and power braking only in deceleration; power braking wins.
// RULE_18 - Stop mode code 1 selects DC braking; codes 3, 5, 6 and 7 reserved.
// RULE_19 - Bus voltage threshold for power braking is a parameter.
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module mss_sequencer
    import mss_pkg::*;
#(
    parameter logic [9:0] BUS_V_LIMIT = 10'h2EE,
    parameter int         TICK_CYC    = MSS_TICK_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        run_cmd,
    input  wire logic [5:0]  mfi_function,
    input  wire logic        mfi_active,
    input  wire logic [15:0] out_freq,
    input  wire logic [15:0] ref_freq,
    input  wire logic [15:0] base_freq,
    input  wire logic [15:0] dwell_freq,
    input  wire logic [8:0]  input_volt,
    input  wire logic [9:0]  bus_volt,
    output mss_drive_t       drive,
    output logic      [8:0]  out_volt,
    output logic             dwell_skip
);
    if (TICK_CYC < 1) begin : g_tick_check
        $error("TICK_CYC must be at least 1");
    end

    // Configuration registers, then sequencer state and timers
    logic        start_dc;
    logic        sensorless_induction_control;
    logic [2:0]  stop_mode;
    logic [7:0]  stall_prevention_config;
    logic [12:0] start_brake_time;
    logic [12:0] output_block_interval;
    logic [12:0] dc_injection_duration;
    logic [7:0]  dc_brake_then_start_level;
    logic [7:0]  dc_injection_level;
    logic [15:0] dc_injection_threshold_freq;
    logic [8:0]  motor_rated_volt;
    logic [7:0]  level_cap;
    logic [8:0]  sampled_volt;
    mss_state_t  state;
    logic [12:0] ticks;
    logic [31:0] prescale;
    logic        tick;

    wire wr_en = psel && penable && pwrite;
    wire [12:0] wt_a = (pwdata[12:0] > MSS_TIME_MAX) ? MSS_TIME_MAX : pwdata[12:0];
    wire [12:0] wt_b = (pwdata[28:16] > MSS_TIME_MAX) ? MSS_TIME_MAX : pwdata[28:16];

    // Software writes; settings take effect at the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_dc                     <= 1'b0;
            sensorless_induction_control <= 1'b0;
            stop_mode                    <= MSS_STOP_DEC;
            stall_prevention_config      <= 8'h00;
            start_brake_time             <= MSS_RST_STARTBRK;
            output_block_interval        <= MSS_RST_BLOCK;
            dc_injection_duration        <= MSS_RST_DCTIME;
            dc_brake_then_start_level               <= MSS_RST_LEVEL;
            dc_injection_level           <= MSS_RST_LEVEL;
            dc_injection_threshold_freq  <= MSS_RST_DCFREQ;
            motor_rated_volt             <= 9'h000;
            level_cap                    <= 8'hFF;
        end else if (wr_en) begin
            case (paddr)
                MSS_REG_CTRL: begin
                    start_dc                     <= pwdata[0];
                    sensorless_induction_control <= pwdata[1];
                    // Reserved stop codes fall back to plain deceleration
                    stop_mode <= (pwdata[6:4] == 3'h3 || pwdata[6:4] > 3'h4) ? MSS_STOP_DEC : pwdata[6:4]; // RULE_18
                    stall_prevention_config      <= pwdata[15:8];
                end
                MSS_REG_TIMES: begin
                    output_block_interval <= wt_a;
                    dc_injection_duration <= wt_b;
                end
                MSS_REG_DCBRK: begin
                    start_brake_time   <= wt_a;
                    dc_brake_then_start_level     <= pwdata[23:16];
                    dc_injection_level <= pwdata[31:24];
                end
                MSS_REG_FREQ: begin
                    dc_injection_threshold_freq <= (pwdata[15:0] > MSS_FREQ_MAX) ? MSS_FREQ_MAX : pwdata[15:0];
                end
                MSS_REG_RATED: begin
                    // Out-of-range voltages are ignored to keep a valid setting
                    if (pwdata[8:0] == 9'h000 || (pwdata[8:0] >= MSS_VRATED_MIN && pwdata[8:0] <= MSS_VRATED_MAX))
                        motor_rated_volt <= pwdata[8:0];
                    level_cap <= pwdata[23:16];
                end
                default: ;
            endcase
        end
    end

    // APB answers with zero wait states; unmapped address errors
    always_comb begin
        pready  = 1'b1;
        pslverr = psel && penable && (paddr > MSS_REG_VOUT || paddr[1:0] != 2'b00);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                MSS_REG_CTRL:   prdata <= {16'h0000, stall_prevention_config, 1'b0, stop_mode, 2'b00,
                                           sensorless_induction_control, start_dc};
                MSS_REG_TIMES:  prdata <= {3'b000, dc_injection_duration, 3'b000, output_block_interval};
                MSS_REG_DCBRK:  prdata <= {dc_injection_level, dc_brake_then_start_level, 3'b000, start_brake_time};
                MSS_REG_FREQ:   prdata <= {16'h0000, dc_injection_threshold_freq};
                MSS_REG_RATED:  prdata <= {8'h00, level_cap, 7'h00, motor_rated_volt};
                MSS_REG_STATUS: prdata <= {16'h0000, ticks, state};
                MSS_REG_VOUT:   prdata <= {23'h000000, out_volt};
                default:        prdata <= 32'h0000_0000;
            endcase
        end
    end

    // 10 ms time base for all phase timers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale <= 32'h0000_0000;
            tick     <= 1'b0;
        end else begin
            tick     <= (prescale == 32'(TICK_CYC - 1));
            prescale <= (prescale == 32'(TICK_CYC - 1)) ? 32'h0000_0000 : prescale + 32'h0000_0001;
        end
    end

    wire dc_brake_then_start_ok  = start_dc && !sensorless_induction_control; // RULE_05 RULE_06
    wire preexcite    = mfi_active && (mfi_function == MSS_FN_PREEXCITE);
    wire at_threshold = out_freq <= dc_injection_threshold_freq;
    wire at_zero      = out_freq == 16'h0000;

    // Start and stop sequencing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= MSS_ST_STOP;
            ticks <= 13'h0000;
        end else begin
            case (state)
                MSS_ST_STOP: begin
                    ticks <= 13'h0000;
                    if (run_cmd)
                        state <= dc_brake_then_start_ok ? MSS_ST_DCST : MSS_ST_RUN; // RULE_04
                end
                MSS_ST_DCST: begin
                    if (!run_cmd) begin
                        state <= MSS_ST_STOP;
                    end else if (ticks >= start_brake_time) begin
                        state <= MSS_ST_RUN; // RULE_05
                        ticks <= 13'h0000;
                    end else if (tick) begin
                        ticks <= ticks + 13'h0001;
                    end
                end
                MSS_ST_RUN: begin
                    if (!run_cmd)
                        state <= (stop_mode == MSS_STOP_FREERUN) ? MSS_ST_STOP : MSS_ST_DEC; // RULE_15
                end
                MSS_ST_DEC: begin
                    if (run_cmd)
                        state <= MSS_ST_RUN;
                    else if (stop_mode == MSS_STOP_DCBRAKE && at_threshold) begin
                        state <= MSS_ST_BLOCK; // RULE_10
                        ticks <= 13'h0000;
                    end else if (at_zero)
                        state <= MSS_ST_STOP; // RULE_09
                end
                MSS_ST_BLOCK: begin
                    if (ticks >= output_block_interval) begin
                        state <= MSS_ST_DCBRK; // RULE_11
                        ticks <= 13'h0000;
                    end else if (tick) begin
                        ticks <= ticks + 13'h0001;
                    end
                end
                MSS_ST_DCBRK: begin
                    if (ticks >= dc_injection_duration)
                        state <= MSS_ST_STOP; // RULE_12
                    else if (tick)
                        ticks <= ticks + 13'h0001;
                end
                default: state <= MSS_ST_STOP;
            endcase
        end
    end

    // Capture input voltage only in the stop state so scaling never jumps mid-run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            sampled_volt <= 9'h000;
        else if (state == MSS_ST_STOP)
            sampled_volt <= input_volt; // RULE_01
    end

    // Output voltage at base frequency, clamped above it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            out_volt <= 9'h000;
        else if (motor_rated_volt == 9'h000)
            out_volt <= sampled_volt; // RULE_01
        else if (out_freq > base_freq && input_volt < motor_rated_volt)
            out_volt <= input_volt; // RULE_03
        else
            out_volt <= motor_rated_volt; // RULE_02
    end

    // Level caps: level_cap holds inverter/motor current ratio x100
    wire [7:0] start_lvl = (dc_brake_then_start_level > level_cap) ? level_cap : dc_brake_then_start_level;         // RULE_07
    wire [7:0] brake_lvl = (dc_injection_level > level_cap) ? level_cap : dc_injection_level; // RULE_13
    wire       decel     = state == MSS_ST_DEC;
    wire       power_brk = decel && stop_mode == MSS_STOP_POWER && bus_volt > BUS_V_LIMIT; // RULE_16 RULE_19

    // Drive outputs registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive      <= '0;
            dwell_skip <= 1'b0;
        end else begin
            drive.gate_on   <= state == MSS_ST_RUN || decel || state == MSS_ST_DCST || state == MSS_ST_DCBRK
                               || (state == MSS_ST_STOP && preexcite && !run_cmd);
            drive.dc_inject <= state == MSS_ST_DCST || state == MSS_ST_DCBRK
                               || (state == MSS_ST_STOP && preexcite && !run_cmd); // RULE_08
            drive.dc_level  <= (state == MSS_ST_DCBRK) ? brake_lvl :
                               (state == MSS_ST_DCST || state == MSS_ST_STOP) ? start_lvl : 8'h00;
            drive.ramp_up   <= state == MSS_ST_RUN && out_freq < ref_freq; // RULE_04
            drive.ramp_down <= decel && !power_brk;
            drive.hold_ramp <= power_brk; // RULE_16
            drive.stall_en  <= decel && stall_prevention_config[3] && stop_mode != MSS_STOP_POWER; // RULE_17
            dwell_skip      <= stop_mode == MSS_STOP_DCBRAKE && dwell_freq < dc_injection_threshold_freq; // RULE_14
        end
    end

    property p_free_run;
        @(posedge pclk) disable iff (!presetn)
        (state == MSS_ST_RUN && !run_cmd && stop_mode == MSS_STOP_FREERUN) |=> state == MSS_ST_STOP ##1 !drive.gate_on;
    endproperty
    a_free_run: assert property (p_free_run) else $error("free run did not cut output"); // RULE_15

    property p_no_dc_sensorless;
        @(posedge pclk) disable iff (!presetn)
        (state == MSS_ST_STOP && run_cmd && sensorless_induction_control) |=> state == MSS_ST_RUN;
    endproperty
    a_no_dc_sensorless: assert property (p_no_dc_sensorless) else $error("Dc_brake_then_start in sensorless"); // RULE_06

    property p_start_cap;
        @(posedge pclk) disable iff (!presetn)
        drive.dc_inject |-> drive.dc_level <= $past(level_cap);
    endproperty
    a_start_cap: assert property (p_start_cap) else $error("DC level above cap"); // RULE_07

    // Block first, then either stay blocked or move on to injection
    sequence s_block_phase;
        state == MSS_ST_BLOCK ##1 (state == MSS_ST_BLOCK || state == MSS_ST_DCBRK);
    endsequence
    property p_block_then_brake;
        @(posedge pclk) disable iff (!presetn)
        (state == MSS_ST_DEC && !run_cmd && stop_mode == MSS_STOP_DCBRAKE && at_threshold) |=> s_block_phase;
    endproperty
    a_block_then_brake: assert property (p_block_then_brake) else $error("no block before brake"); // RULE_11

    property p_block_no_gate;
        @(posedge pclk) disable iff (!presetn)
        $past(state) == MSS_ST_BLOCK |-> !drive.gate_on;
    endproperty
    a_block_no_gate: assert property (p_block_no_gate) else $error("output on during block"); // RULE_11

    property p_power_priority;
        @(posedge pclk) disable iff (!presetn)
        stop_mode == MSS_STOP_POWER && $stable(stop_mode) |=> !drive.stall_en;
    endproperty
    a_power_priority: assert property (p_power_priority) else $error("stall on with power braking"); // RULE_17

    property p_preexcite;
        @(posedge pclk) disable iff (!presetn)
        (state == MSS_ST_STOP && preexcite && !run_cmd) |=> drive.dc_inject;
    endproperty
    a_preexcite: assert property (p_preexcite) else $error("no pre-excitation"); // RULE_08

    property p_brake_ends;
        @(posedge pclk) disable iff (!presetn)
        (state == MSS_ST_DCBRK && ticks >= dc_injection_duration) |=> state == MSS_ST_STOP;
    endproperty
    a_brake_ends: assert property (p_brake_ends) else $error("DC brake overran"); // RULE_12
endmodule : mss_sequencer
`default_nettype wire
